/* acc_host_model.sv */
// Host model driving the serial port of the converter.
`timescale 1ns/1ps
module acc_host_model (
    output logic      link_sclk_o,
    output logic      tfs_n_o,
    output logic      rfs_n_o,
    output logic      a0_o,
    output logic      sdata_o,
    input  wire logic sdata_i
);
    initial begin
        link_sclk_o = 1'b0;
        tfs_n_o = 1'b1;
        rfs_n_o = 1'b1;
        a0_o = 1'b0;
        sdata_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The serial clock runs only inside a frame.
    task automatic xfer(input logic wr, input logic sel, input int n, input logic [23:0] w,
                        output logic [23:0] r);
        r = 24'h000000;
        a0_o = sel;
        #200;
        if (wr) begin
            tfs_n_o = 1'b0;
        end else begin
            rfs_n_o = 1'b0;
        end
        for (int i = 0; i < n; i++) begin
            sdata_o = (i < 24) ? w[23-i] : ~w[0];
            #15;
            r = {r[22:0], sdata_i};
            link_sclk_o = 1'b1;
            #15;
            link_sclk_o = 1'b0;
        end
        #10;
        tfs_n_o = 1'b1;
        rfs_n_o = 1'b1;
        sdata_o = ~sdata_o;
        #400;
    endtask
endmodule

/* acc_mode_cal_ctrl.sv */
// Control word decoder, calibration sequencer and serial port of the converter.
//
// Behaviour
// RULE_01: 24-bit control word, MSB first, notch code low.
// RULE_02: Normal mode reads with select high return result.
// RULE_03: Mode bits reset to normal mode.
// RULE_04: Mode 001 runs self-calibration on selected channel.
// RULE_05: Finished self-calibration clears mode bits to normal.
// RULE_06: Self-calibration completion drives data-ready low.
// RULE_07: Mode 010 zero-scale system step, then normal.
// RULE_08: Mode 011 full-scale system step, then normal.
// RULE_09: Mode 100 system offset calibration, then normal.
// RULE_10: Mode 101 background calibration, one word per six.
// RULE_11: Background mode keeps refreshing calibration coefficients.
// RULE_12: Mode 110 select-high access hits zero coefficient.
// RULE_13: Mode 111 select-high access hits full coefficient.
// RULE_14: Coefficient transfers are always 24 bits.
// RULE_15: Short coefficient writes are discarded entirely.
// RULE_16: Select-low targets control word; only full writes.
// RULE_17: Data-ready falls on new word, rises after readout.
// RULE_18: Gain codes are powers of two, default one.
// RULE_19: Word length bit picks 16 or 24 bits.
// RULE_20: Host starts full step after zero step completes.
// RULE_21: No conversion data-ready during a calibration.
`timescale 1ns/1ps
module acc_mode_cal_ctrl
    import acc_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input  wire logic      clock_i,
    input  wire logic      rst_n_i,
    input  wire logic      link_sclk_i,
    input  wire logic      transmit_frame_n_i,
    input  wire logic      receive_frame_n_i,
    input  wire logic      register_select_pin_i,
    input  wire logic      sdata_i,
    output logic           sdata_o,
    output logic           sdata_oe_o,
    output logic           data_ready_n_o,
    input  wire acc_meas_t meas_i,
    output acc_src_t       fe_src_o,
    output acc_cfg_t       cfg_o,
    output logic           cal_busy_o
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CAL_ZERO,
        ST_CAL_FULL
    } acc_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [CW_W-1:0]   ctrl_q;
    logic [COEF_W-1:0] zero_coef_q [CHANNELS];
    logic [COEF_W-1:0] full_coef_q [CHANNELS];
    logic [COEF_W-1:0] result_q;
    logic [CW_W-1:0]   rd_word_q;
    logic [CW_W-1:0]   rd_word_d;
    acc_state_t        state_q;
    logic [2:0]        cal_mode_q;
    logic [2:0]        slot_q;
    logic              data_ready_n_n_q;
    logic              result_new;
    logic              cal_done;

    logic [CW_W-1:0]   wr_word;
    logic              wr_a0;
    logic              wr_tog;
    logic              rd_done_tog;
    logic [1:0]        tog_sync;
    logic              sel_sync;
    logic              rfs_sync;
    logic [1:0]        tog_prev_q;
    logic              wr_evt;
    logic              rd_evt;

    logic [2:0]        mode;
    logic              ch;
    logic              wr_ctrl;
    logic              wr_coef;
    logic              mode_write;
    logic              coef_sel_zero;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial link and crossing

    // Written word and select level are held stable by the link until the next full
    // word, so sampling them on the synchronised toggle edge is safe.
    acc_serial_link u_link (
        .link_sclk_i           (link_sclk_i),
        .rst_n_i               (rst_n_i),
        .transmit_frame_n_i    (transmit_frame_n_i),
        .receive_frame_n_i     (receive_frame_n_i),
        .register_select_pin_i (register_select_pin_i),
        .sdata_i               (sdata_i),
        .sdata_o               (sdata_o),
        .sdata_oe_o            (sdata_oe_o),
        .rd_word_i             (rd_word_q),
        .rd_long_i             (cfg_o.output_word_length_select |
                                (register_select_pin_i & ((mode == MODE_RW_ZERO) | (mode == MODE_RW_FULL)))), // [RULE_14]
        .wr_word_o             (wr_word),
        .wr_a0_o               (wr_a0),
        .wr_tog_o              (wr_tog),
        .rd_done_tog_o         (rd_done_tog)
    );

    acc_sync2 #(
        .WIDTH (4)
    ) u_tog_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({wr_tog, rd_done_tog, register_select_pin_i, receive_frame_n_i}),
        .sync_o  ({tog_sync, sel_sync, rfs_sync})
    );

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_prev_q <= '0;
        end else begin
            tog_prev_q <= tog_sync;
        end
    end

    assign wr_evt = tog_sync[1] ^ tog_prev_q[1];
    assign rd_evt = tog_sync[0] ^ tog_prev_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Control word

    assign mode    = ctrl_q[MODE_MSB:MODE_LSB];
    assign ch      = ctrl_q[CH_BIT];
    assign wr_ctrl = wr_evt & ~wr_a0; // [RULE_16]
    assign wr_coef = wr_evt & wr_a0 & ((mode == MODE_RW_ZERO) | (mode == MODE_RW_FULL));
    assign coef_sel_zero = (mode == MODE_RW_ZERO);

    // A new control word starting one of the one-shot calibrations.
    assign mode_write = wr_ctrl & ((wr_word[MODE_MSB:MODE_LSB] == MODE_SELF_CAL) |
                                   (wr_word[MODE_MSB:MODE_LSB] == MODE_SYS_ZERO) |
                                   (wr_word[MODE_MSB:MODE_LSB] == MODE_SYS_FULL) |
                                   (wr_word[MODE_MSB:MODE_LSB] == MODE_SYS_OFFS));

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CW_RESET; // [RULE_03]
        end else if (wr_ctrl) begin
            ctrl_q <= wr_word; // [RULE_01]
        end else if (cal_done) begin
            ctrl_q[MODE_MSB:MODE_LSB] <= MODE_NORMAL; // [RULE_05] [RULE_07] [RULE_08] [RULE_09]
        end
    end

    always_comb begin
        cfg_o.gain_factor               = GAIN_ONE << ctrl_q[GAIN_MSB:GAIN_LSB]; // [RULE_18]
        cfg_o.input_channel_select      = ch;
        cfg_o.power_down_request        = ctrl_q[PD_BIT];
        cfg_o.output_word_length_select = ctrl_q[WL_BIT];
        cfg_o.comp_current_enable       = ctrl_q[IO_BIT];
        cfg_o.burnout_current_enable    = ctrl_q[BO_BIT];
        cfg_o.unipolar_select           = ctrl_q[BU_BIT];
        cfg_o.filter_notch_code         = ctrl_q[FS_MSB:FS_LSB]; // [RULE_01]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= ST_IDLE;
            cal_mode_q <= MODE_NORMAL;
        end else if (mode_write) begin
            cal_mode_q <= wr_word[MODE_MSB:MODE_LSB];
            if (wr_word[MODE_MSB:MODE_LSB] == MODE_SYS_FULL) begin
                state_q <= ST_CAL_FULL; // [RULE_08] [RULE_20]
            end else begin
                state_q <= ST_CAL_ZERO; // [RULE_04] [RULE_07] [RULE_09]
            end
        end else if (wr_ctrl) begin
            // Any other control write abandons a calibration in flight.
            state_q <= ST_IDLE;
        end else if (meas_i.valid) begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_CAL_ZERO: begin
                    if (cal_mode_q == MODE_SYS_ZERO) begin
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_CAL_FULL;
                    end
                end
                ST_CAL_FULL: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign cal_done   = meas_i.valid & ~wr_ctrl & ((state_q == ST_CAL_FULL) |
                        ((state_q == ST_CAL_ZERO) & (cal_mode_q == MODE_SYS_ZERO)));
    assign cal_busy_o = (state_q != ST_IDLE);

    // Background mode rotates through the slots; only slot zero yields an output word.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_q <= SLOT_ZERO;
        end else if (mode != MODE_BACKGND) begin
            slot_q <= SLOT_ZERO;
        end else if (meas_i.valid) begin
            slot_q <= (slot_q == BG_LAST) ? SLOT_ZERO : slot_q + 3'(1); // [RULE_10]
        end
    end

    // Front-end source: shorted inputs or the reference for internal calibration steps.
    always_comb begin
        fe_src_o = SRC_CHANNEL;
        case (state_q)
            ST_CAL_ZERO: begin
                if (cal_mode_q == MODE_SELF_CAL) begin
                    fe_src_o = SRC_SHORT; // [RULE_04]
                end
            end
            ST_CAL_FULL: begin
                if (cal_mode_q == MODE_SELF_CAL || cal_mode_q == MODE_SYS_OFFS) begin
                    fe_src_o = SRC_REF; // [RULE_04] [RULE_09]
                end
            end
            default: begin
                if (mode == MODE_BACKGND && slot_q != SLOT_ZERO) begin
                    fe_src_o = slot_q[0] ? SRC_SHORT : SRC_REF; // [RULE_10]
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Coefficient store

    // Coefficients are always whole 24-bit words; a host write only lands here after
    // the link has counted the full word.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                zero_coef_q[i] <= COEF_RESET;
                full_coef_q[i] <= COEF_RESET;
            end
        end else if (wr_coef) begin // [RULE_14] [RULE_15]
            if (coef_sel_zero) begin
                zero_coef_q[ch] <= wr_word; // [RULE_12]
            end else begin
                full_coef_q[ch] <= wr_word; // [RULE_13]
            end
        end else if (meas_i.valid && !wr_ctrl) begin
            if (state_q == ST_CAL_ZERO) begin
                zero_coef_q[ch] <= meas_i.value; // [RULE_04] [RULE_07] [RULE_09]
            end else if (state_q == ST_CAL_FULL) begin
                full_coef_q[ch] <= meas_i.value; // [RULE_04] [RULE_08] [RULE_09]
            end else if (mode == MODE_BACKGND && slot_q != SLOT_ZERO) begin
                if (slot_q[0]) begin
                    zero_coef_q[ch] <= meas_i.value; // [RULE_11]
                end else begin
                    full_coef_q[ch] <= meas_i.value; // [RULE_11]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion result and data-ready

    // Conversion words are taken only outside calibration, while powered up, and in
    // background mode only in the signal slot.
    assign result_new = meas_i.valid & (state_q == ST_IDLE) & ~ctrl_q[PD_BIT] &
                        ((mode == MODE_NORMAL) |
                         ((mode == MODE_BACKGND) & (slot_q == SLOT_ZERO))); // [RULE_10] [RULE_21]

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_q <= COEF_RESET;
        end else if (result_new) begin
            result_q <= meas_i.value;
        end
    end

    // A new word or a finished calibration wins over a readout that ends the same cycle.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_ready_n_n_q <= 1'b1;
        end else if (result_new || cal_done) begin
            data_ready_n_n_q <= 1'b0; // [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_17]
        end else if (rd_evt) begin
            data_ready_n_n_q <= 1'b1; // [RULE_17]
        end
    end

    assign data_ready_n_o = data_ready_n_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read word

    // The link reads this word on its own clock; it is only reloaded while the
    // synchronised read frame pin is high, so it holds still during a read.
    always_comb begin
        rd_word_d = result_q; // [RULE_02]
        if (!sel_sync) begin
            rd_word_d = ctrl_q; // [RULE_16]
        end else if (mode == MODE_RW_ZERO) begin
            rd_word_d = zero_coef_q[ch]; // [RULE_12]
        end else if (mode == MODE_RW_FULL) begin
            rd_word_d = full_coef_q[ch]; // [RULE_13]
        end
    end

    // The word is registered so the link never sees a decode glitch.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_word_q <= WORD_ZERO;
        end else if (rfs_sync) begin
            rd_word_q <= rd_word_d; // [RULE_14] [RULE_19]
        end
    end

endmodule

/* acc_mode_cal_ctrl_chk.sv */
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
module acc_mode_cal_ctrl_chk
    import acc_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic      clock_i,
    input wire logic      rst_n_i,
    input wire logic      transmit_frame_n_i,
    input wire logic      receive_frame_n_i,
    input wire logic      sdata_oe_o,
    input wire logic      data_ready_n_o,
    input wire acc_meas_t meas_i,
    input wire acc_cfg_t  cfg_o,
    input wire logic      cal_busy_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic [7:0] since_rd_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_rd_q <= 8'hFF;
        end else if (!receive_frame_n_i) begin
            since_rd_q <= 8'h00;
        end else if (since_rd_q != 8'hFF) begin
            since_rd_q <= since_rd_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_reset_gain: assert property ($rose(rst_n_i) |-> cfg_o.gain_factor == GAIN_ONE && data_ready_n_o)
        else $error("gain or ready wrong after reset");
    chk_gain_onehot: assert property ($onehot(cfg_o.gain_factor))
        else $error("gain factor not a power of two");
    chk_oe_in_frame: assert property (sdata_oe_o |-> !receive_frame_n_i)
        else $error("serial data driven outside a read frame");
    chk_busy_ready: assert property (cal_busy_o |-> !$fell(data_ready_n_o))
        else $error("ready raised during calibration");
    chk_cal_done: assert property ($fell(cal_busy_o) && $past(meas_i.valid) |-> !data_ready_n_o)
        else $error("calibration end without ready");
    chk_ready_cause: assert property ($fell(data_ready_n_o) |-> $past(meas_i.valid))
        else $error("ready fell without a measurement");
    chk_ready_hold: assert property ($rose(data_ready_n_o) |-> since_rd_q <= 8'h08)
        else $error("ready released without a read");
    chk_cfg_frame: assert property ($changed(cfg_o) |-> !$past(transmit_frame_n_i, 6))
        else $error("configuration changed without a write");
endmodule

bind acc_mode_cal_ctrl acc_mode_cal_ctrl_chk #(.CHANNELS(CHANNELS)) u_chk (.*);

/* acc_mode_cal_ctrl_tb.sv */
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
module acc_mode_cal_ctrl_tb;
    import acc_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        sclk, tfs_n, rfs_n, a0, host_sd, sd_o, sd_oe, data_ready_n_n, busy;
    wire         sd_line = sd_oe ? sd_o : host_sd;
    acc_meas_t   meas = '0;
    acc_src_t    src;
    acc_cfg_t    cfg;
    int          mismatches = 0;
    int          comparisons = 0;
    logic [23:0] rd, cw;
    logic [2:0]  last_md [4] = '{MODE_RW_FULL, MODE_RW_ZERO, MODE_RW_FULL, MODE_RW_FULL};
    acc_src_t    first_src [4] = '{SRC_SHORT, SRC_CHANNEL, SRC_CHANNEL, SRC_CHANNEL};

    always #20 clock_i = ~clock_i;

    acc_host_model host (.link_sclk_o(sclk), .tfs_n_o(tfs_n), .rfs_n_o(rfs_n), .a0_o(a0), .sdata_o(host_sd),
        .sdata_i(sd_line));
    acc_mode_cal_ctrl #(.CHANNELS(2)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .link_sclk_i(sclk),
        .transmit_frame_n_i(tfs_n), .receive_frame_n_i(rfs_n), .register_select_pin_i(a0), .sdata_i(sd_line),
        .sdata_o(sd_o), .sdata_oe_o(sd_oe), .data_ready_n_o(data_ready_n_n), .meas_i(meas), .fe_src_o(src), .cfg_o(cfg),
        .cal_busy_o(busy));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [25:0] seen, input logic [25:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic xw(input logic sel, input logic [23:0] w, input int n);
        host.xfer(1'b1, sel, n, w, rd);
    endtask
    // Reads send ones, so undriven bits read as ones.
    task automatic xr(input logic sel, input int n);
        host.xfer(1'b0, sel, n, 24'hFFFFFF, rd);
    endtask
    task automatic ctl(input logic [2:0] md, input logic ch);
        xw(1'b0, {md, 3'h0, ch, 1'b0, 1'b1, 15'h0000}, 24);
    endtask
    task automatic pulse(input logic [23:0] v);
        @(posedge clock_i) meas <= '{valid: 1'b1, value: v};
        @(posedge clock_i) meas <= '0;
        repeat (2) @(posedge clock_i);
    endtask

    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        check(data_ready_n_n, 1'b1, "ready after reset");
        check(cfg.gain_factor, GAIN_ONE, "gain after reset");
        xr(1'b0, 17);
        check(rd[16:0], 17'h00001, "control after reset");
        $display("test reset done");
        for (int g = 0; g < 8; g++) begin
            cw = {3'h0, 3'(g), 6'h08, 12'(g * 273)};
            xw(1'b0, cw, 24);
            check(cfg.gain_factor, 24'(8'h01 << g), "gain");
            check(cfg.filter_notch_code, 12'(g * 273), "notch");
            xr(1'b0, 24);
            check(rd, cw, "control readback");
        end
        cw = {3'h0, 3'h5, 6'h09, 12'h3C7};
        xw(1'b0, cw, 12);
        check(cfg.gain_factor, 8'h80, "short control write");
        xw(1'b0, cw, 30);
        check(cfg, {8'h20, 6'h09, 12'h3C7}, "long control write");
        $display("test control done");
        pulse(24'h5A3C96);
        check(data_ready_n_n, 1'b0, "ready after result");
        xr(1'b1, 24);
        check(rd, 24'h5A3C96, "result read");
        check(data_ready_n_n, 1'b1, "ready after readout");
        xw(1'b0, {3'h0, 3'h5, 6'h01, 12'h3C7}, 24);
        pulse(24'hC3A55A);
        xr(1'b1, 17);
        check(rd[16:0], {16'hC3A5, 1'b1}, "short result read");
        check(data_ready_n_n, 1'b1, "ready after short readout");
        $display("test result done");
        for (int m = 6; m < 8; m++) begin
            ctl(3'(m), 1'b1);
            xw(1'b1, 24'h123450 + 24'(m), 24);
            xw(1'b1, 24'hFFFFFF, 20);
            xr(1'b1, 24);
            check(rd, 24'h123450 + 24'(m), "coefficient");
        end
        ctl(MODE_RW_ZERO, 1'b0);
        xr(1'b1, 24);
        check(rd, 24'h000000, "other channel coef");
        $display("test coefficients done");
        // The full step follows a finished zero step.
        for (int m = 1; m < 5; m++) begin
            ctl(3'(m), 1'b0);
            check(busy, 1'b1, "cal busy");
            check(src, first_src[m-1], "first source");
            if (m == 1 || m == 4) begin
                pulse(24'h0F0F00 + 24'(m));
                check(data_ready_n_n, 1'b1, "ready mid cal");
                check(src, SRC_REF, "second source");
            end
            pulse(24'hABC000 + 24'(m));
            check(busy, 1'b0, "cal end");
            check(data_ready_n_n, 1'b0, "cal ready");
            xr(1'b0, 24);
            check(rd[23:21], MODE_NORMAL, "mode cleared");
            ctl(last_md[m-1], 1'b0);
            xr(1'b1, 24);
            check(rd, 24'hABC000 + 24'(m), "stored coef");
        end
        $display("test calibration done");
        ctl(MODE_BACKGND, 1'b0);
        for (int s = 0; s < 12; s++) begin
            check(src, (s % 6 == 0) ? SRC_CHANNEL : ((s % 2 == 1) ? SRC_SHORT : SRC_REF), "slot");
            pulse(24'h600000 + 24'(s));
            check(data_ready_n_n, (s % 6 != 0), "bg ready");
            if (s % 6 == 0) begin
                xr(1'b1, 24);
                check(rd, 24'h600000 + 24'(s), "bg result");
            end
        end
        ctl(MODE_RW_ZERO, 1'b0);
        xr(1'b1, 24);
        check(rd, 24'h60000B, "bg zero coef");
        ctl(MODE_RW_FULL, 1'b0);
        xr(1'b1, 24);
        check(rd, 24'h60000A, "bg full coef");
        $display("test background done");
        tally_and_finish();
    end
endmodule

/* acc_pkg.sv */
// Shared constants, field layout and types of the converter control block.
package acc_pkg;

    localparam int CW_W      = 24;
    localparam int CNT_W     = 5;
    localparam int COEF_W    = 24;
    localparam int WORD_SHORT = 16;
    localparam int WORD_LONG  = 24;

    // Field positions inside the control word.
    localparam int MODE_MSB  = 23;
    localparam int MODE_LSB  = 21;
    localparam int GAIN_MSB  = 20;
    localparam int GAIN_LSB  = 18;
    localparam int CH_BIT    = 17;
    localparam int PD_BIT    = 16;
    localparam int WL_BIT    = 15;
    localparam int IO_BIT    = 14;
    localparam int BO_BIT    = 13;
    localparam int BU_BIT    = 12;
    localparam int FS_MSB    = 11;
    localparam int FS_LSB    = 0;

    localparam logic [CW_W-1:0]   CW_RESET   = 24'h000000;
    localparam logic [COEF_W-1:0] COEF_RESET = 24'h000000;
    localparam logic [CW_W-1:0]   WORD_ZERO  = 24'h000000;

    // Operating mode codes.
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_SELF_CAL = 3'h1;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] MODE_SYS_OFFS = 3'h4;
    localparam logic [2:0] MODE_BACKGND  = 3'h5;
    localparam logic [2:0] MODE_RW_ZERO  = 3'h6;
    localparam logic [2:0] MODE_RW_FULL  = 3'h7;

    // Background calibration spends this many measurement slots per output word.
    localparam int              BG_SLOTS  = 6;
    localparam logic [2:0]      BG_LAST   = 3'(BG_SLOTS - 1);
    localparam logic [2:0]      SLOT_ZERO = 3'h0;
    localparam logic [7:0]      GAIN_ONE  = 8'h01;

    typedef enum logic [1:0] {
        SRC_CHANNEL,
        SRC_SHORT,
        SRC_REF
    } acc_src_t;

    typedef struct packed {
        logic              valid;
        logic [COEF_W-1:0] value;
    } acc_meas_t;

    typedef struct packed {
        logic [7:0]       gain_factor;
        logic             input_channel_select;
        logic             power_down_request;
        logic             output_word_length_select;
        logic             comp_current_enable;
        logic             burnout_current_enable;
        logic             unipolar_select;
        logic [FS_MSB:0]  filter_notch_code;
    } acc_cfg_t;

endpackage

/* acc_serial_link.sv */
// Serial port logic clocked by the host's serial clock.
`timescale 1ns/1ps
module acc_serial_link
    import acc_pkg::*;
(
    input  wire logic            link_sclk_i,
    input  wire logic            rst_n_i,
    input  wire logic            transmit_frame_n_i,
    input  wire logic            receive_frame_n_i,
    input  wire logic            register_select_pin_i,
    input  wire logic            sdata_i,
    output logic                 sdata_o,
    output logic                 sdata_oe_o,
    input  wire logic [CW_W-1:0] rd_word_i,
    input  wire logic            rd_long_i,
    output logic      [CW_W-1:0] wr_word_o,
    output logic                 wr_a0_o,
    output logic                 wr_tog_o,
    output logic                 rd_done_tog_o
);

    logic [CNT_W-1:0] wr_cnt_q;
    logic [CW_W-1:0]  wr_sh_q;
    logic [CNT_W-1:0] rd_cnt_q;
    logic [CNT_W-1:0] rd_len;
    logic             wr_arst_n;
    logic             rd_arst_n;
    logic             wr_last;
    logic             rd_last;

    // The clock stops between frames, so the frame pin itself clears the counters.
    assign wr_arst_n = rst_n_i & ~transmit_frame_n_i;
    assign rd_arst_n = rst_n_i & ~receive_frame_n_i;
    assign wr_last   = (wr_cnt_q == CNT_W'(CW_W - 1));
    assign rd_len    = rd_long_i ? CNT_W'(WORD_LONG) : CNT_W'(WORD_SHORT);
    assign rd_last   = (rd_cnt_q == rd_len - CNT_W'(1));

    always_ff @(posedge link_sclk_i or negedge wr_arst_n) begin
        if (!wr_arst_n) begin
            wr_cnt_q <= '0;
            wr_sh_q  <= '0;
        end else if (wr_cnt_q < CNT_W'(CW_W)) begin // [RULE_16]
            wr_cnt_q <= wr_cnt_q + CNT_W'(1);
            wr_sh_q  <= {wr_sh_q[CW_W-2:0], sdata_i}; // [RULE_01]
        end
    end

    // Only a full word is handed on; a short frame never reaches this point.
    always_ff @(posedge link_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_word_o <= WORD_ZERO;
            wr_a0_o   <= 1'b0;
            wr_tog_o  <= 1'b0;
        end else if (!transmit_frame_n_i && wr_last) begin // [RULE_15] [RULE_16]
            wr_word_o <= {wr_sh_q[CW_W-2:0], sdata_i};
            wr_a0_o   <= register_select_pin_i;
            wr_tog_o  <= ~wr_tog_o;
        end
    end

    always_ff @(posedge link_sclk_i or negedge rd_arst_n) begin
        if (!rd_arst_n) begin
            rd_cnt_q <= '0;
        end else if (rd_cnt_q < rd_len) begin
            rd_cnt_q <= rd_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge link_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_done_tog_o <= 1'b0;
        end else if (!receive_frame_n_i && rd_last) begin // [RULE_17]
            rd_done_tog_o <= ~rd_done_tog_o;
        end
    end

    // Most significant bit leaves first.
    assign sdata_oe_o = ~receive_frame_n_i & (rd_cnt_q < rd_len);
    assign sdata_o    = sdata_oe_o ? rd_word_i[CNT_W'(CW_W - 1) - rd_cnt_q] : 1'b0; // [RULE_01]

endmodule

/* acc_sync2.sv */
// Two-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
module acc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule
